//--- hw/gdcd_map.vh
/*
  Register map, field positions, reset values and encodings of the gated
  down counter / divider. Included by the top-level design file only; holds definitions only.
*/
`ifndef GDCD_MAP_VH
`define GDCD_MAP_VH

// Byte offsets of the register words
`define GDCD_REG_CTRL 8'h00
`define GDCD_REG_CFG 8'h04
`define GDCD_REG_DIV 8'h08
`define GDCD_REG_TB 8'h0C
`define GDCD_REG_STATUS 8'h10
`define GDCD_REG_COUNT 8'h14

// Control word bits (write-one actions, read as zero)
`define GDCD_CTRL_START 0
`define GDCD_CTRL_STOP 1
`define GDCD_CTRL_TCCLR 2

// Configuration fields
`define GDCD_CFG_GATE 2:0
`define GDCD_CFG_EDGE 4
`define GDCD_CFG_OUT 9:8
`define GDCD_CFG_MASK 32'h0000_0317

// Status bits
`define GDCD_ST_RUN 0
`define GDCD_ST_WAIT 1
`define GDCD_ST_OUT 2
`define GDCD_ST_TC 3
`define GDCD_ST_SRC 4

// Reset values and 32-bit word constants
`define GDCD_CFG_RST 32'h0000_0000
`define GDCD_DIV_RST 32'h0000_0002
`define GDCD_TB_RST 32'h0000_0000
`define GDCD_ZERO32 32'h0000_0000
`define GDCD_ONE32 32'h0000_0001

// Gate selections
`define GDCD_GATE_NONE 3'h0
`define GDCD_GATE_HIGH 3'h1
`define GDCD_GATE_LOW 3'h2
`define GDCD_GATE_RISE 3'h3
`define GDCD_GATE_FALL 3'h4

// Bus responses
`define GDCD_RESP_OKAY 2'h0
`define GDCD_RESP_SLVERR 2'h2

`endif

//--- hw/gdcd_sync.v
/*
  Two-flop synchroniser for a group of asynchronous pin inputs.
  Assumes the pins are slow compared with mclk; only the second stage is visible.
*/
`timescale 1ns/1ps
module gdcd_sync #(
  parameter W = 2
) (
  // Clock and reset
  input wire mclk,
  input wire srst,
  // Pins in, synchronised copy out
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge mclk) begin
    if (srst) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule

//--- hw/gdcd_top.v
/*
  Gated down counter / divider with an AXI4-Lite register slave.
  Assumes source and gate pins are asynchronous TTL levels slower than mclk/4,
  and a single 50 MHz mclk with synchronous active-high reset srst.
*/
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
// Behaviour
// R1: Count down divisor, output equals input over divisor
// R2: Timebase zero selects source pin edges
// R3: Gate selection 0: ignore gate, run at start
// R4: Gate selection 1: count while gate high
// R5: Gate selection 2: count while gate low
// R6: Gate selection 3: begin at gate rising edge
// R7: Gate selection 4: begin at gate falling edge
// R8: Edge select: 0 rising, 1 falling counted
// R9: Output mode 0: one-cycle high pulse
// R10: Output mode 1: one-cycle low pulse
// R11: Output mode 2: toggle, starting high
// R12: Output mode 3: toggle, starting low
// R13: Toggle divides by twice divisor, pulse once
// R14: Reload at terminal count without losing edges
// R15: Idle before start, output inactive level
`timescale 1ns/1ps
`include "gdcd_map.vh"
module gdcd_top #(
  parameter CNT_W = 32,
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire mclk,
  input wire srst,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Counter pins
  input wire counter_source_pin,
  input wire counter_gate_pin,
  output wire counter_output_pin
);

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_RUN = 2'h2;

  // Merge write data into a register under the byte strobes
  function [31:0] apply_strb;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      apply_strb = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          apply_strb[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // Word-aligned byte offset, low address bits ignored
  function [7:0] word_off;
    input [ADDR_W-1:0] a;
    begin
      word_off = {a[7:2], 2'b00};
    end
  endfunction

  // Registers
  reg [31:0] cfg_ff;
  reg [CNT_W-1:0] div_ff;
  reg [31:0] tb_div_ff;
  reg tc_seen_ff;

  // AXI write side
  reg aw_full_ff;
  reg [ADDR_W-1:0] aw_addr_ff;
  reg w_full_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  // AXI read side
  reg rvalid_ff;
  reg [1:0] rresp_ff;
  reg [31:0] rdata_ff;

  // Counter core
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [CNT_W-1:0] count_ff;
  reg [31:0] tb_cnt_ff;
  reg tb_sig_ff;
  reg in_prev_ff;
  reg gate_prev_ff;
  reg act_ff;
  reg phase_ff;
  reg out_ff;

  wire [1:0] pin_sync;
  wire src_sync;
  wire gate_sync;
  wire do_write;
  wire [7:0] w_off;
  wire [7:0] r_off;
  wire ctrl_wr;
  wire start_cmd;
  wire stop_cmd;
  wire tc_clr;
  wire use_src;
  wire in_sig;
  wire cnt_edge;
  wire gate_rise;
  wire gate_fall;
  wire [2:0] gate_sel;
  wire [1:0] out_mode;
  wire [CNT_W-1:0] div_eff;
  wire tb_wrap;
  reg run_en;
  reg tc;

  gdcd_sync #(
    .W(2)
  ) u_sync (
    .mclk(mclk),
    .srst(srst),
    .d({counter_gate_pin, counter_source_pin}),
    .q(pin_sync)
  );

  assign src_sync = pin_sync[0];
  assign gate_sync = pin_sync[1];

  // Write channel: address and data are held independently, then committed
  assign s_axi_awready = ~aw_full_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_full_ff & ~bvalid_ff;
  assign do_write = aw_full_ff & w_full_ff & ~bvalid_ff;
  assign w_off = word_off(aw_addr_ff);
  assign ctrl_wr = do_write & (w_off == `GDCD_REG_CTRL) & w_strb_ff[0];
  assign start_cmd = ctrl_wr & w_data_ff[`GDCD_CTRL_START];
  assign stop_cmd = ctrl_wr & w_data_ff[`GDCD_CTRL_STOP];
  assign tc_clr = ctrl_wr & w_data_ff[`GDCD_CTRL_TCCLR];

  always @(posedge mclk) begin
    if (srst) begin
      aw_full_ff <= 1'b0;
      aw_addr_ff <= {ADDR_W{1'b0}};
      w_full_ff <= 1'b0;
      w_data_ff <= `GDCD_ZERO32;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `GDCD_RESP_OKAY;
      cfg_ff <= `GDCD_CFG_RST;
      div_ff <= `GDCD_DIV_RST;
      tb_div_ff <= `GDCD_TB_RST;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= `GDCD_RESP_OKAY;
        case (w_off)
          `GDCD_REG_CTRL: begin
          end
          `GDCD_REG_CFG: begin
            cfg_ff <= apply_strb(cfg_ff, w_data_ff, w_strb_ff) & `GDCD_CFG_MASK;
          end
          `GDCD_REG_DIV: begin
            div_ff <= apply_strb(div_ff, w_data_ff, w_strb_ff);
          end
          `GDCD_REG_TB: begin
            tb_div_ff <= apply_strb(tb_div_ff, w_data_ff, w_strb_ff);
          end
          `GDCD_REG_STATUS: begin
          end
          `GDCD_REG_COUNT: begin
          end
          default: begin
            bresp_ff <= `GDCD_RESP_SLVERR;
          end
        endcase
      end else if (bvalid_ff & s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Read channel: one outstanding read, data registered
  assign s_axi_arready = ~rvalid_ff;
  assign r_off = word_off(s_axi_araddr);

  always @(posedge mclk) begin
    if (srst) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= `GDCD_RESP_OKAY;
      rdata_ff <= `GDCD_ZERO32;
    end else if (s_axi_arvalid & ~rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= `GDCD_RESP_OKAY;
      rdata_ff <= `GDCD_ZERO32;
      case (r_off)
        `GDCD_REG_CTRL: begin
          rdata_ff <= `GDCD_ZERO32;
        end
        `GDCD_REG_CFG: begin
          rdata_ff <= cfg_ff;
        end
        `GDCD_REG_DIV: begin
          rdata_ff <= div_ff;
        end
        `GDCD_REG_TB: begin
          rdata_ff <= tb_div_ff;
        end
        `GDCD_REG_STATUS: begin
          rdata_ff[`GDCD_ST_RUN] <= (state_ff == ST_RUN);
          rdata_ff[`GDCD_ST_WAIT] <= (state_ff == ST_WAIT);
          rdata_ff[`GDCD_ST_OUT] <= out_ff;
          rdata_ff[`GDCD_ST_TC] <= tc_seen_ff;
          rdata_ff[`GDCD_ST_SRC] <= use_src;
        end
        `GDCD_REG_COUNT: begin
          rdata_ff <= count_ff;
        end
        default: begin
          rresp_ff <= `GDCD_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff & s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  assign gate_sel = cfg_ff[`GDCD_CFG_GATE];
  assign out_mode = cfg_ff[`GDCD_CFG_OUT];
  // A divisor of zero is loaded as one, giving a terminal count on every counted edge
  assign div_eff = (div_ff == `GDCD_ZERO32) ? `GDCD_ONE32 : div_ff;

  // Internal timebase: square wave of tb_div_ff mclk cycles per half period
  assign use_src = (tb_div_ff == `GDCD_ZERO32); // [R2]
  assign tb_wrap = (tb_cnt_ff >= tb_div_ff - `GDCD_ONE32);

  always @(posedge mclk) begin
    if (srst | use_src) begin
      tb_cnt_ff <= `GDCD_ZERO32;
      tb_sig_ff <= 1'b0;
    end else if (tb_wrap) begin
      tb_cnt_ff <= `GDCD_ZERO32;
      tb_sig_ff <= ~tb_sig_ff;
    end else begin
      tb_cnt_ff <= tb_cnt_ff + `GDCD_ONE32;
    end
  end

  // Counted input and its selected edge
  assign in_sig = use_src ? src_sync : tb_sig_ff; // [R1] [R2]
  assign cnt_edge = cfg_ff[`GDCD_CFG_EDGE] ? (in_prev_ff & ~in_sig) : (~in_prev_ff & in_sig); // [R8]
  assign gate_rise = ~gate_prev_ff & gate_sync;
  assign gate_fall = gate_prev_ff & ~gate_sync;

  always @(posedge mclk) begin
    if (srst) begin
      in_prev_ff <= 1'b0;
      gate_prev_ff <= 1'b0;
    end else begin
      in_prev_ff <= in_sig;
      gate_prev_ff <= gate_sync;
    end
  end

  // Arming and gating state
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_state = ST_IDLE; // [R15]
      end
      ST_WAIT: begin
        if ((gate_sel == `GDCD_GATE_RISE) & gate_rise) begin
          nxt_state = ST_RUN; // [R6]
        end else if ((gate_sel == `GDCD_GATE_FALL) & gate_fall) begin
          nxt_state = ST_RUN; // [R7]
        end
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Edge-started modes wait for the gate; the edge must come after the start
    if (start_cmd) begin
      if ((gate_sel == `GDCD_GATE_RISE) | (gate_sel == `GDCD_GATE_FALL)) begin
        nxt_state = ST_WAIT; // [R6] [R7]
      end else begin
        nxt_state = ST_RUN; // [R3]
      end
    end
    if (stop_cmd) begin
      nxt_state = ST_IDLE;
    end
  end

  // Level gating acts only while running; unlisted selections count ungated
  always @* begin
    run_en = 1'b0;
    if (state_ff == ST_RUN) begin
      case (gate_sel)
        `GDCD_GATE_HIGH: begin
          run_en = gate_sync; // [R4]
        end
        `GDCD_GATE_LOW: begin
          run_en = ~gate_sync; // [R5]
        end
        default: begin
          run_en = 1'b1; // [R3]
        end
      endcase
    end
    tc = run_en & cnt_edge & (count_ff <= `GDCD_ONE32);
  end

  // Down counter, pulse and toggle phase
  always @(posedge mclk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      count_ff <= {CNT_W{1'b0}};
      act_ff <= 1'b0;
      phase_ff <= 1'b0;
      tc_seen_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (start_cmd | stop_cmd) begin
        count_ff <= div_eff;
        act_ff <= 1'b0;
        phase_ff <= start_cmd & ~stop_cmd; // [R11] [R12] [R15]
      end else if (state_ff == ST_IDLE) begin
        act_ff <= 1'b0; // [R15]
        phase_ff <= 1'b0;
      end else if (run_en & cnt_edge) begin
        if (tc) begin
          count_ff <= div_eff; // [R14]
          phase_ff <= ~phase_ff; // [R13]
        end else begin
          count_ff <= count_ff - `GDCD_ONE32; // [R1]
        end
        // Pulse spans from one counted edge to the next
        act_ff <= tc; // [R9] [R10] [R13]
      end
      // A terminal count in the clearing cycle keeps the flag set
      if (tc) begin
        tc_seen_ff <= 1'b1;
      end else if (tc_clr) begin
        tc_seen_ff <= 1'b0;
      end
    end
  end

  // Output level: bit 1 of the mode picks toggle, bit 0 inverts
  always @(posedge mclk) begin
    if (srst) begin
      out_ff <= 1'b0;
    end else if (out_mode[1]) begin
      out_ff <= phase_ff ^ out_mode[0]; // [R11] [R12]
    end else begin
      out_ff <= act_ff ^ out_mode[0]; // [R9] [R10]
    end
  end

  assign counter_output_pin = out_ff;

endmodule

//--- tb/gdcd_pins_model.sv
/*
  Partner model: TTL drivers of the source and gate pins of the counter.
  Assumes mclk from the bench; half is the source half-period in mclk cycles.
*/
`timescale 1ns/1ps
module gdcd_pins_model (
  // Clock
  input wire mclk,
  // Requests from the bench
  input wire run,
  input wire [3:0] half,
  input wire gate_req,
  // Pins
  output logic counter_source_pin,
  output logic counter_gate_pin
);
  logic [3:0] cnt_ff;
  initial begin
    counter_source_pin = 1'b0;
    counter_gate_pin = 1'b0;
    cnt_ff = 4'h0;
  end
  // Source is parked at its last level between bursts, as a stopped TTL driver would be
  always @(posedge mclk) begin
    counter_gate_pin <= gate_req;
    if (!run) begin
      cnt_ff <= 4'h0;
    end else if (cnt_ff + 4'h1 >= half) begin
      cnt_ff <= 4'h0;
      counter_source_pin <= !counter_source_pin;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule

//--- tb/gdcd_checker_assertions.sv
/*
  Concurrent checks on the ports of gdcd_top.
  Assumes aligned AXI writes whose address and data are offered together.
*/
`timescale 1ns/1ps
module gdcd_checker #(
  parameter CNT_W = 32,
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire mclk,
  input wire srst,
  // Write side
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  // Read side
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  // Pin
  input wire counter_output_pin
);
  reg [1:0] mode_ff;
  wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ctl_go = wr_go && s_axi_awaddr[7:2] == 6'h00 && s_axi_wstrb[0];
  wire ar_go = s_axi_arvalid && s_axi_arready;
  // Shadow of the output mode, needed to know the idle level
  always @(posedge mclk) begin
    if (srst) mode_ff <= 2'h0;
    else if (wr_go && s_axi_awaddr[7:2] == 6'h01 && s_axi_wstrb[1]) mode_ff <= s_axi_wdata[9:8];
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);
  reset_idle_a:
    assert property ($fell(srst) |-> !counter_output_pin) else $error("output active after reset");
  stop_idle_a:
    assert property (ctl_go && s_axi_wdata[1] |-> ##3 counter_output_pin == mode_ff[0])
      else $error("output not idle after stop");
  start_level_a:
    assert property (ctl_go && s_axi_wdata[0] && !s_axi_wdata[1] |-> ##3 counter_output_pin == (mode_ff[1] ^ mode_ff[0]))
      else $error("wrong output level after start");
  wr_resp_a:
    assert property (wr_go |-> ##2 s_axi_bvalid) else $error("write response late");
  wr_err_a:
    assert property (wr_go && s_axi_awaddr >= 8'h18 |-> ##2 s_axi_bresp == 2'h2) else $error("unmapped write not refused");
  rd_resp_a:
    assert property (ar_go |=> s_axi_rvalid) else $error("read data late");
  rd_err_a:
    assert property (ar_go && s_axi_araddr >= 8'h18 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
  rd_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read address taken while busy");
endmodule
bind gdcd_top gdcd_checker #(.CNT_W(CNT_W), .ADDR_W(ADDR_W)) u_chk (.*);

//--- tb/gdcd_top_tb.sv
/*
  Self-checking bench for gdcd_top: AXI4-Lite master, pin partner and an edge-count model.
  Assumes one-cycle bus answers and a few mclk from a pin edge to the output pin.
*/
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
  tests_run++; \
  if ((a) !== (e)) begin \
    mismatches++; \
    $display("unexpected %s exp %0h got %0h", n, e, a); \
  end \
end
module gdcd_top_tb;
  logic mclk = 1'b0, srst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, run = 1'b0, gate_req = 1'b0, prev = 1'b0, l0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] half = 4'h3;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire counter_source_pin, counter_gate_pin, counter_output_pin;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int mismatches = 0, tests_run = 0, tcs = 0, len = 0, last_len, act_len, counted, g, m, e, dv, base;
  always #10 mclk = !mclk;
  gdcd_top DUT (.*, .s_axi_wstrb(4'hf));
  gdcd_pins_model u_pins (.*);
  // Terminal counts seen at the pin: active-going edges in pulse modes, every change in toggle modes
  always @(posedge mclk) begin
    if (counter_output_pin !== prev) begin
      if (m >= 2 || counter_output_pin === (m != 1)) tcs++;
      if (prev === (m != 1)) act_len = len;
      last_len = len;
      len = 1;
    end else len++;
    prev = counter_output_pin;
  end
  task automatic print_verdict();
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    // Ready stays high between calls so that back-to-back calls never assign it twice in one step
    `CHK("bresp", er, s_axi_bresp)
    if (n == 40) begin
      mismatches++;
      print_verdict();
    end
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] mk, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    `CHK("rdata", d, s_axi_rdata & mk)
    `CHK("rresp", er, s_axi_rresp)
    if (n == 40) begin
      mismatches++;
      print_verdict();
    end
  endtask
  // Gate is changed only while the source is parked, so no counted edge straddles it
  task automatic burst(input int n, input logic lvl, input logic en);
    int k;
    logic p;
    gate_req <= lvl;
    repeat (6) @(posedge mclk);
    run <= 1'b1;
    p = counter_source_pin;
    for (k = 0; n > 0 && k < 400; k++) begin
      @(posedge mclk);
      if (counter_source_pin !== p) begin
        n--;
        if (en && counter_source_pin === !e[0]) counted++;
        p = counter_source_pin;
      end
    end
    run <= 1'b0;
    repeat (8) @(posedge mclk);
    if (n > 0) begin
      mismatches++;
      print_verdict();
    end
  endtask
  initial begin
    void'($urandom(12534));
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    axr(8'h04, 32'h0000_0000, 32'hffff_ffff, 2'h0);
    axr(8'h08, 32'h0000_0002, 32'hffff_ffff, 2'h0);
    axr(8'h0c, 32'h0000_0000, 32'hffff_ffff, 2'h0);
    axr(8'h00, 32'h0000_0000, 32'hffff_ffff, 2'h0);
    axr(8'h10, 32'h0000_0010, 32'h0000_0010, 2'h0);
    axr(8'h20, 32'h0000_0000, 32'hffff_ffff, 2'h2);
    axw(8'h1c, 32'h0000_0001, 2'h2);
    axw(8'h04, 32'hffff_ffff, 2'h0);
    axr(8'h04, 32'h0000_0317, 32'hffff_ffff, 2'h0);
    for (g = 0; g < 6; g++) begin
      m = g % 4;
      e = $urandom % 2;
      dv = (m < 2) ? 2 + $urandom % 3 : 1 + $urandom % 4;
      half <= 4'(3 + $urandom % 3);
      l0 = (g == 2 || g == 4);
      axw(8'h00, 32'h0000_0002, 2'h0);
      axw(8'h08, dv, 2'h0);
      axw(8'h04, (m << 8) | (e << 4) | g, 2'h0);
      gate_req <= l0;
      repeat (6) @(posedge mclk);
      `CHK("idle", m[0], counter_output_pin)
      axw(8'h00, 32'h0000_0001, 2'h0);
      repeat (4) @(posedge mclk);
      `CHK("start", m[1] ^ m[0], counter_output_pin)
      axr(8'h10, (g == 3 || g == 4) ? 32'h0000_0002 : 32'h0000_0000, 32'h0000_0002, 2'h0);
      counted = 0;
      base = tcs;
      burst(1 + $urandom % 6, l0, g == 0 || g == 5);
      burst(1 + $urandom % 6, !l0, 1'b1);
      burst(1 + $urandom % 6, l0, g != 1 && g != 2);
      `CHK("tcs", counted / dv, tcs - base)
    end
    m = 1;
    half <= 4'h4;
    axw(8'h00, 32'h0000_0002, 2'h0);
    axw(8'h08, 32'h0000_0003, 2'h0);
    axw(8'h04, 32'h0000_0100 | (e << 4), 2'h0);
    axw(8'h00, 32'h0000_0001, 2'h0);
    burst(14, 1'b0, 1'b1);
    `CHK("pulse", 8, act_len)
    // Seven counted edges against a divisor of three leave two to go
    axr(8'h14, 32'h0000_0002, 32'hffff_ffff, 2'h0);
    axr(8'h10, 32'h0000_001d, 32'h0000_001f, 2'h0);
    axw(8'h00, 32'h0000_0004, 2'h0);
    axr(8'h10, 32'h0000_0000, 32'h0000_0008, 2'h0);
    m = 2;
    axw(8'h00, 32'h0000_0002, 2'h0);
    axw(8'h04, 32'h0000_0200, 2'h0);
    axw(8'h0c, 32'h0000_0002, 2'h0);
    axr(8'h10, 32'h0000_0000, 32'h0000_0010, 2'h0);
    axw(8'h00, 32'h0000_0001, 2'h0);
    repeat (100) @(posedge mclk);
    `CHK("period", 12, last_len)
    axw(8'h00, 32'h0000_0002, 2'h0);
    axw(8'h0c, 32'h0000_0000, 2'h0);
    print_verdict();
  end
endmodule
